// >>> logic/arc_trip_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef ARC_TRIP_MAP_SVH
`define ARC_TRIP_MAP_SVH
// -----------------------------------------------------------------------------
// Timing.
// -----------------------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define PRG_CYCLE_NS    5000
`define PRG_CLKS        (`PRG_CYCLE_NS / `CLK_PERIOD_NS)
`define BLOCK_LEAD_MS   5
`define REC_DEPTH       12
// -----------------------------------------------------------------------------
// Byte offsets.
// -----------------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_ZONE_CFG0   8'h04
`define OFS_ARC_ON_SEL  8'h14
`define OFS_ARC_OFF_SEL 8'h18
`define OFS_GN_SEL      8'h1c
`define OFS_ARC_COND    8'h20
`define OFS_SENS_STAT   8'h24
`define OFS_ARC_CNT     8'h28
`define OFS_START_CNT   8'h2c
`define OFS_TRIP_CNT    8'h30
`define OFS_GN_COND     8'h34
`define OFS_REC_SEL     8'h38
`define OFS_REC_W0      8'h3c
`define OFS_REC_W4      8'h4c
// -----------------------------------------------------------------------------
// Fields.
// -----------------------------------------------------------------------------
`define CTRL_FORCE_EN   0
`define CTRL_ARC_CLR    4
`define CTRL_START_CLR  5
`define CTRL_TRIP_CLR   6
`define NUM_EVENTS      26
`define CTRL_RESET      32'h0000_0000
`endif

// >>> logic/arc_trip_pkg.sv
// Types shared by the arc trip and record store logic.
package arc_trip_pkg;
   typedef enum logic [2:0] {
      COND_NORMAL = 3'b001,
      COND_START  = 3'b010,
      COND_TRIP   = 3'b100
   } gn_cond_t;
   typedef enum logic [1:0] {
      FORCE_NORMAL = 2'h0,
      FORCE_START  = 2'h1,
      FORCE_TRIP   = 2'h2
   } force_t;
   typedef enum logic [1:0] {
      DI_OFF      = 2'h0,
      DI_LIGHT    = 2'h1,
      DI_CURRENT  = 2'h2
   } di_mode_t;
endpackage

// >>> logic/op_record_ring.sv
// Twelve-entry store of operation records, newest read at index zero.
`timescale 1ns/1ns
`include "arc_trip_map.svh"
module op_record_ring
   import arc_trip_pkg::*;
(
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   input  wire logic         i_wr,
   input  wire logic [127:0] i_wdata,
   input  wire logic [3:0]   i_rd_idx,
   output logic      [127:0] o_rdata,
   output logic      [3:0]   o_count
);
   logic [127:0] mem_reg [`REC_DEPTH];
   logic [3:0]   wr_ptr_reg;
   logic [3:0]   cnt_reg;
   logic [4:0]   phys_tmp;
   logic [3:0]   phys_idx;

   // ----------------------------------------------------------------------
   // Write side.
   // ----------------------------------------------------------------------
   // The pointer wraps, so the oldest entry is the one overwritten.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_ptr_reg <= 4'h0;
         cnt_reg    <= 4'h0;
      end else if (i_wr) begin
         wr_ptr_reg <= (wr_ptr_reg == 4'(`REC_DEPTH - 1)) ? 4'h0 :
                       wr_ptr_reg + 4'h1;
         if (cnt_reg != 4'(`REC_DEPTH))
            cnt_reg <= cnt_reg + 4'h1;
      end
   end

   // Storage is not reset; the count hides entries never written.
   always_ff @(posedge i_clk) begin
      if (i_wr)
         mem_reg[wr_ptr_reg] <= i_wdata;
   end

   // ----------------------------------------------------------------------
   // Read side.
   // ----------------------------------------------------------------------
   // Index zero is the newest record, counting back to the oldest.
   always_comb begin
      phys_tmp = 5'(wr_ptr_reg) + 5'(`REC_DEPTH - 1) - 5'(i_rd_idx);
      if (phys_tmp >= 5'(`REC_DEPTH))
         phys_tmp = phys_tmp - 5'(`REC_DEPTH);
      phys_idx = phys_tmp[3:0];
   end

   always_ff @(posedge i_clk) begin
      if (i_srst)
         o_rdata <= '0;
      else if (i_rd_idx < cnt_reg)
         o_rdata <= mem_reg[phys_idx];
      else
         o_rdata <= '0;
   end

   assign o_count = cnt_reg;
endmodule

// >>> logic/arc_trip_block_event_logic.sv
// Arc zone trip/block logic, event sources and common signal aggregator.
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ns
`include "arc_trip_map.svh"
module arc_trip_block_event_logic
   import arc_trip_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_block,
   input  wire logic [3:0]  i_light,
   input  wire logic [3:0]  i_pressure,
   input  wire logic        i_di,
   input  wire logic [3:0]  i_sensor_fault,
   input  wire logic        i_io_fault,
   input  wire logic        i_ph_start,
   input  wire logic        i_ph_blocked,
   input  wire logic        i_res_start,
   input  wire logic        i_res_blocked,
   input  wire logic [15:0] i_cur_a,
   input  wire logic [15:0] i_cur_b,
   input  wire logic [15:0] i_cur_c,
   input  wire logic [15:0] i_cur_res,
   input  wire logic [2:0]  i_setting_group,
   input  wire logic [47:0] i_time_ms,
   input  wire logic [7:0]  i_prot_start,
   input  wire logic [7:0]  i_prot_trip,
   input  wire logic        i_extra_start,
   input  wire logic        i_extra_trip,
   output logic      [3:0]  o_zone_trip,
   output logic      [3:0]  o_zone_blocked,
   output logic      [25:0] o_arc_ev_on,
   output logic      [25:0] o_arc_ev_off,
   output logic      [3:0]  o_gn_ev,
   output logic      [47:0] o_ev_stamp,
   output logic             o_common_start,
   output logic             o_common_trip
);
   logic [14:0]  pin_meta_reg;
   logic [14:0]  pin_sync_reg;
   logic         blk_sync;
   logic [3:0]   light_s;
   logic [3:0]   pres_s;
   logic         di_s;
   logic [3:0]   fault_s;
   logic         io_fault_s;
   logic [7:0]   tick_cnt_reg;
   logic         tick;
   logic         blk_smp_reg;
   logic [10:0]  zone_cfg_reg [4];
   logic [3:0]   pickup;
   logic [3:0]   trip_reg;
   logic [3:0]   blkd_reg;
   logic [25:0]  mon_vec;
   logic [25:0]  mon_prev_reg;
   logic [25:0]  on_sel_reg;
   logic [25:0]  off_sel_reg;
   logic [25:0]  ev_on;
   logic [25:0]  ev_off;
   logic [31:0]  arc_cnt_reg;
   logic [31:0]  start_cnt_reg;
   logic [31:0]  trip_cnt_reg;
   logic [3:0]   gn_sel_reg;
   logic         force_en_reg;
   force_t       force_reg;
   gn_cond_t     gn_cond_reg;
   logic         raw_start;
   logic         raw_trip;
   logic         forcing;
   logic [3:0]   gn_ev;
   logic         rec_wr;
   logic [2:0]   rec_zone;
   logic [127:0] rec_wdata;
   logic [127:0] rec_rdata;
   logic [3:0]   rec_count;
   logic [3:0]   rec_sel_reg;
   logic         ack_reg;
   logic         wr_go;
   logic [31:0]  rd_mux;
   logic [31:0]  zone_rd;

   // ----------------------------------------------------------------------
   // Pin synchronisers.
   // ----------------------------------------------------------------------
   // Sensor and blocking pins are asynchronous and pass two flops.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pin_meta_reg <= 15'h0000;
         pin_sync_reg <= 15'h0000;
      end else begin
         pin_meta_reg <= {i_block, i_io_fault, i_sensor_fault, i_di,
                          i_pressure, i_light};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   assign light_s    = pin_sync_reg[3:0];
   assign pres_s     = pin_sync_reg[7:4];
   assign di_s       = pin_sync_reg[8];
   assign fault_s    = pin_sync_reg[12:9];
   assign io_fault_s = pin_sync_reg[13];
   assign blk_sync   = pin_sync_reg[14];

   // ----------------------------------------------------------------------
   // Program cycle timer.
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst || tick)
         tick_cnt_reg <= 8'h00;
      else
         tick_cnt_reg <= tick_cnt_reg + 8'h01;
   end
   assign tick = (tick_cnt_reg == 8'(`PRG_CLKS - 1));

   // ----------------------------------------------------------------------
   // Zone pick-up.
   // ----------------------------------------------------------------------
   // Config: [0] enable, [4:1] light, [8:5] pressure, [10:9] input mode.
   for (genvar z = 0; z < 4; z++) begin : g_zone
      logic sens_hit;
      assign sens_hit = |((light_s & zone_cfg_reg[z][4:1]) |
                          (pres_s & zone_cfg_reg[z][8:5]));
      assign pickup[z] = zone_cfg_reg[z][0] & (sens_hit |
         (zone_cfg_reg[z][10:9] == DI_LIGHT && di_s) |
         (zone_cfg_reg[z][10:9] == DI_CURRENT && di_s &&
          |(light_s | pres_s)));
   end

   // ----------------------------------------------------------------------
   // Trip or blocked decision, once per program cycle.
   // ----------------------------------------------------------------------
   // A blocked pick-up stays blocked until it drops; a late block cannot
   // withdraw a trip, hence the lead time that the block source must keep.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         blk_smp_reg <= 1'b0;
         trip_reg    <= 4'h0;
         blkd_reg    <= 4'h0;
      end else if (tick) begin
         blk_smp_reg <= blk_sync;
         for (int z = 0; z < 4; z++) begin
            if (!pickup[z]) begin
               trip_reg[z] <= 1'b0;
               blkd_reg[z] <= 1'b0;
            end else if (!trip_reg[z] && !blkd_reg[z]) begin
               trip_reg[z] <= !blk_sync;
               blkd_reg[z] <= blk_sync;
            end
         end
      end
   end
   assign o_zone_trip    = trip_reg;
   assign o_zone_blocked = blkd_reg;

   // ----------------------------------------------------------------------
   // Arc events and counter.
   // ----------------------------------------------------------------------
   assign mon_vec = {io_fault_s, fault_s, di_s, pres_s, light_s,
                     i_res_start, i_res_blocked, i_ph_start, i_ph_blocked,
                     blkd_reg, trip_reg};
   assign ev_on  = mon_vec & ~mon_prev_reg & on_sel_reg;
   assign ev_off = ~mon_vec & mon_prev_reg & off_sel_reg;

   // Changes are sampled one clock after the decision so both agree.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         mon_prev_reg <= 26'h0;
         o_arc_ev_on  <= 26'h0;
         o_arc_ev_off <= 26'h0;
         o_gn_ev      <= 4'h0;
         o_ev_stamp   <= 48'h0;
      end else begin
         mon_prev_reg <= mon_vec;
         o_arc_ev_on  <= ev_on;
         o_arc_ev_off <= ev_off;
         o_gn_ev      <= gn_ev;
         if ((|ev_on) || (|ev_off) || (|gn_ev))
            o_ev_stamp <= i_time_ms;
      end
   end

   // A clear in the same cycle as new events keeps the new events.
   always_ff @(posedge i_clk) begin
      if (i_srst)
         arc_cnt_reg <= 32'h0;
      else
         arc_cnt_reg <= (wr_go && i_avs_address == `OFS_CTRL &&
                         i_avs_writedata[`CTRL_ARC_CLR] ? 32'h0 :
                         arc_cnt_reg) + 32'($countones({ev_on, ev_off}));
   end

   // ----------------------------------------------------------------------
   // Operation records on a new zone trip.
   // ----------------------------------------------------------------------
   // Only the lowest zone tripping in a cycle is recorded.
   always_comb begin
      rec_zone = 3'h0;
      for (int z = 3; z >= 0; z--)
         if (trip_reg[z] && !mon_prev_reg[z])
            rec_zone = 3'(z + 1);
   end
   assign rec_wr    = (rec_zone != 3'h0);
   // One pad bit makes the record exactly 128 bits wide.
   assign rec_wdata = {1'h0, i_setting_group, light_s | pres_s,
                       i_cur_res, i_cur_c, i_cur_b, i_cur_a,
                       5'h00, rec_zone, i_time_ms};

   op_record_ring u_rec (
      .i_clk    (i_clk),
      .i_srst   (i_srst),
      .i_wr     (rec_wr),
      .i_wdata  (rec_wdata),
      .i_rd_idx (rec_sel_reg),
      .o_rdata  (rec_rdata),
      .o_count  (rec_count)
   );

   // ----------------------------------------------------------------------
   // Common signal aggregator.
   // ----------------------------------------------------------------------
   // No block input exists here; suppression belongs to each function.
   assign raw_start = (|i_prot_start) | (|trip_reg) |
                      i_extra_start;
   assign raw_trip  = (|i_prot_trip) | (|trip_reg) |
                      i_extra_trip;
   assign forcing   = force_en_reg && force_reg != FORCE_NORMAL;

   // Settings are plain registers, independent of the setting group.
   always_ff @(posedge i_clk) begin
      if (i_srst)
         gn_cond_reg <= COND_NORMAL;
      else if (forcing)
         gn_cond_reg <= (force_reg == FORCE_TRIP) ? COND_TRIP :
                        COND_START;
      else if (raw_trip)
         gn_cond_reg <= COND_TRIP;
      else if (raw_start)
         gn_cond_reg <= COND_START;
      else
         gn_cond_reg <= COND_NORMAL;
   end
   assign o_common_start = gn_cond_reg != COND_NORMAL;
   assign o_common_trip  = gn_cond_reg == COND_TRIP;

   // Events: [0] start on, [1] start off, [2] trip on, [3] trip off.
   assign gn_ev = gn_sel_reg & {
      !(raw_trip || forcing && force_reg == FORCE_TRIP) && o_common_trip,
      (raw_trip || forcing && force_reg == FORCE_TRIP) && !o_common_trip,
      !(raw_start || raw_trip || forcing) && o_common_start,
      (raw_start || raw_trip || forcing) && !o_common_start};

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         start_cnt_reg <= 32'h0;
         trip_cnt_reg  <= 32'h0;
      end else begin
         start_cnt_reg <= (wr_go && i_avs_address == `OFS_CTRL &&
                           i_avs_writedata[`CTRL_START_CLR] ? 32'h0 :
                           start_cnt_reg) + 32'(gn_ev[0]);
         trip_cnt_reg  <= (wr_go && i_avs_address == `OFS_CTRL &&
                           i_avs_writedata[`CTRL_TRIP_CLR] ? 32'h0 :
                           trip_cnt_reg) + 32'(gn_ev[2]);
      end
   end

   // ----------------------------------------------------------------------
   // Avalon-MM slave.
   // ----------------------------------------------------------------------
   // One wait state on every access, so read data are registered.
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
   assign wr_go             = i_avs_write & ack_reg;
   assign zone_rd = (i_avs_address >= `OFS_ZONE_CFG0 &&
                     i_avs_address < `OFS_ARC_ON_SEL) ?
                    {21'h0, zone_cfg_reg[i_avs_address[3:2] - 2'h1]} : 32'h0;

   always_ff @(posedge i_clk) begin
      if (i_srst)
         ack_reg <= 1'b0;
      else
         ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         force_en_reg <= 1'b0;
         force_reg    <= FORCE_NORMAL;
         on_sel_reg   <= 26'h0;
         off_sel_reg  <= 26'h0;
         gn_sel_reg   <= 4'h0;
         rec_sel_reg  <= 4'h0;
         for (int z = 0; z < 4; z++)
            zone_cfg_reg[z] <= 11'h000;
      end else if (wr_go) begin
         case (i_avs_address)
            `OFS_CTRL: begin
               force_en_reg <= i_avs_writedata[`CTRL_FORCE_EN];
               force_reg    <= force_t'(i_avs_writedata[2:1]);
            end
            `OFS_ARC_ON_SEL:  on_sel_reg  <= i_avs_writedata[25:0];
            `OFS_ARC_OFF_SEL: off_sel_reg <= i_avs_writedata[25:0];
            `OFS_GN_SEL:      gn_sel_reg  <= i_avs_writedata[3:0];
            `OFS_REC_SEL:     rec_sel_reg <= i_avs_writedata[3:0];
            default: begin
               if (zone_rd != 32'h0 || (i_avs_address >= `OFS_ZONE_CFG0 &&
                   i_avs_address < `OFS_ARC_ON_SEL))
                  zone_cfg_reg[i_avs_address[3:2] - 2'h1] <=
                     i_avs_writedata[10:0];
            end
         endcase
      end
   end

   // Unmapped addresses read as zero.
   always_comb begin
      case (i_avs_address)
         `OFS_CTRL:        rd_mux = {29'h0, force_reg, force_en_reg};
         `OFS_ARC_ON_SEL:  rd_mux = {6'h0, on_sel_reg};
         `OFS_ARC_OFF_SEL: rd_mux = {6'h0, off_sel_reg};
         `OFS_GN_SEL:      rd_mux = {28'h0, gn_sel_reg};
         `OFS_ARC_COND:    rd_mux = {24'h0, blkd_reg, trip_reg};
         `OFS_SENS_STAT:   rd_mux = {14'h0, mon_vec[25:8]};
         `OFS_ARC_CNT:     rd_mux = arc_cnt_reg;
         `OFS_START_CNT:   rd_mux = start_cnt_reg;
         `OFS_TRIP_CNT:    rd_mux = trip_cnt_reg;
         `OFS_GN_COND:     rd_mux = {29'h0, gn_cond_reg};
         `OFS_REC_SEL:     rd_mux = {20'h0, rec_count, 4'h0, rec_sel_reg};
         `OFS_REC_W0:      rd_mux = rec_rdata[31:0];
         8'h40:            rd_mux = rec_rdata[63:32];
         8'h44:            rd_mux = rec_rdata[95:64];
         8'h48:            rd_mux = rec_rdata[127:96];
         `OFS_REC_W4:      rd_mux = 32'h0;
         default:          rd_mux = zone_rd;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst)
         o_avs_readdata <= 32'h0;
      else if (i_avs_read && !ack_reg)
         o_avs_readdata <= rd_mux;
   end

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_fresh_pickup;
      tick && (pickup[0] && !trip_reg[0] && !blkd_reg[0]);
   endsequence

   chk_block_sample: assert property (tick |=> blk_smp_reg == $past(blk_sync))
      else $error("block sample not taken at cycle start");
   chk_trip_free: assert property (s_fresh_pickup and !blk_sync |=>
                                   trip_reg[0] && !blkd_reg[0])
      else $error("unblocked pick-up did not trip");
   chk_blocked_hold: assert property (blkd_reg[0] && pickup[0] |=>
                                      blkd_reg[0] && !trip_reg[0])
      else $error("blocked zone processed further");
   chk_event_on: assert property (tick ##1 (trip_reg[0] && !$past(trip_reg[0])
                                  && on_sel_reg[0]) |=> o_arc_ev_on[0])
      else $error("zone trip on event missing");
   chk_count_clear: assert property (wr_go && i_avs_address == `OFS_CTRL &&
      i_avs_writedata[`CTRL_ARC_CLR] && !(|ev_on) && !(|ev_off) |=>
      arc_cnt_reg == 32'h0)
      else $error("arc counter not cleared");
   chk_rec_bound: assert property (rec_count <= 4'(`REC_DEPTH))
      else $error("record count above twelve");
   chk_common_or: assert property (!forcing && (|i_prot_trip || i_extra_trip)
                                   |=> o_common_trip && o_common_start)
      else $error("common trip not following inputs");
   chk_force_trip: assert property (forcing && force_reg == FORCE_TRIP |=>
                                    gn_cond_reg == COND_TRIP)
      else $error("forced trip not applied");
   chk_force_gate: assert property (!force_en_reg && !raw_start && !raw_trip
                                    |=> gn_cond_reg == COND_NORMAL)
      else $error("override active without stage forcing");
   chk_gn_event: assert property (gn_sel_reg[2] && !o_common_trip &&
                                  $rose(raw_trip) |=> o_gn_ev[2])
      else $error("common trip on event missing");
endmodule

// >>> testbench/pickup_model.sv
// Behavioural model of the pick-up elements and the blocking matrix.
`timescale 1ns/1ns
module pickup_model (
   input  wire logic       i_clk,
   input  wire logic [3:0] i_light_req,
   input  wire logic       i_block_req,
   output logic      [3:0] o_light,
   output logic            o_block
);
   // Both levels start inactive so the device sees no pick-up in reset.
   initial begin
      o_light = 4'h0;
      o_block = 1'b0;
   end
   // Levels change just after an edge, like a registered source would.
   // In the block test the bench raises blocking a whole program cycle ahead of the pick-up.
   always @(posedge i_clk) begin
      o_block <= i_block_req;
      o_light <= i_light_req;
   end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the arc trip and common signal logic.
`timescale 1ns/1ns
module testbench;
   logic        clk, srst, rd, wr, blk_req, blk, di, iof, phs, phb, rss, rsb;
   logic        xs, xt, wq, cst, ctr;
   logic [7:0]  adr, ps, pt;
   logic [31:0] wd, rdata;
   logic [3:0]  lt_req, lt, pr, sf, zt, zb;
   logic [15:0] ca, cb, cc, cr;
   logic [2:0]  sg;
   logic [47:0] tms;
   logic [17:0] r;
   logic [31:0] exp_q[$];
   logic [25:0] evn, evf, on_acc, off_acc;
   logic [3:0]  gev, gacc;
   logic [47:0] stp;
   int          n_errors, n_tests;
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   pickup_model pm_u (.i_clk(clk), .i_light_req(lt_req),
      .i_block_req(blk_req), .o_light(lt), .o_block(blk));
   arc_trip_block_event_logic dut_u (.i_clk(clk), .i_srst(srst),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
      .i_block(blk), .i_light(lt), .i_pressure(pr), .i_di(di),
      .i_sensor_fault(sf), .i_io_fault(iof), .i_ph_start(phs),
      .i_ph_blocked(phb), .i_res_start(rss), .i_res_blocked(rsb),
      .i_cur_a(ca), .i_cur_b(cb), .i_cur_c(cc), .i_cur_res(cr),
      .i_setting_group(sg), .i_time_ms(tms), .i_prot_start(ps),
      .i_prot_trip(pt), .i_extra_start(xs), .i_extra_trip(xt),
      .o_zone_trip(zt), .o_zone_blocked(zb), .o_arc_ev_on(evn),
      .o_arc_ev_off(evf), .o_gn_ev(gev), .o_ev_stamp(stp),
      .o_common_start(cst), .o_common_trip(ctr));
   // Event pulses last one cycle, so they are gathered for later checks.
   always @(posedge clk)
      if (srst) {on_acc, off_acc, gacc} <= '0;
      else {on_acc, off_acc, gacc} <= {on_acc | evn, off_acc | evf,
                                       gacc | gev};
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One bus cycle, held until waitrequest is low at a rising edge.
   // An idle edge follows, since a held request would be acked twice.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wq !== 1'b0 && n < 20);
      if (wq !== 1'b0) begin
         n_errors++;
         tally_and_finish();
      end
      wr <= 0;
      rd <= 0;
      @(posedge clk);
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(0, a, 32'h0);
   endtask
   // Read data is compared at the accepting edge against the oldest note.
   always @(posedge clk)
      if (rd && wq === 1'b0 && exp_q.size() > 0)
         check("readdata", rdata, exp_q.pop_front());
   always @(posedge clk) tms <= tms + 48'h1;
   initial begin
      #5_000_000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      srst = 1;
      {rd, wr, blk_req, di, iof, phs, phb, rss, rsb, xs, xt} = '0;
      {adr, ps, pt, wd, lt_req, pr, sf, sg, tms} = '0;
      void'($urandom(96));
      {ca, cb, cc, cr} = {$urandom, $urandom};
      settle(10);
      srst <= 0;
      rdx(8'h00, 32'h0);
      rdx(8'h34, 32'h1);
      rdx(8'h50, 32'h0);
      $display("test reset done");
      bus(1, 8'h04, 32'h3);
      bus(1, 8'h14, 32'h3ff_ffff);
      bus(1, 8'h1c, 32'hf);
      lt_req <= 4'h1;
      settle(60);
      check("zone_state", 32'({zb, zt}), 32'h01);
      check("common_trip", 32'(ctr), 32'h1);
      rdx(8'h20, 32'h1);
      rdx(8'h28, 32'h2);
      rdx(8'h38, 32'h100);
      check("ev_on_acc", 32'(on_acc), 32'h1001);
      check("gn_ev_acc", 32'(gacc), 32'h5);
      check("stamp_set", 32'(stp != 48'h0), 32'h1);
      rdx(8'h2c, 32'h1);
      rdx(8'h30, 32'h1);
      rdx(8'h40, {ca[7:0], 8'h01, 16'h0});
      bus(1, 8'h00, 32'h10);
      rdx(8'h28, 32'h0);
      $display("test trip done");
      lt_req <= 4'h0;
      settle(60);
      blk_req <= 1;
      settle(60);
      lt_req <= 4'h1;
      settle(60);
      check("zone_state", 32'({zb, zt}), 32'h10);
      rdx(8'h20, 32'h10);
      blk_req <= 0;
      lt_req <= 4'h0;
      settle(60);
      $display("test block done");
      ps <= 8'($urandom) | 8'h01;
      pt <= 8'($urandom) | 8'h80;
      settle(3);
      check("common_pair", 32'({cst, ctr}), 32'h3);
      {ps, pt, xs, xt} <= 18'h3;
      settle(3);
      check("common_pair", 32'({cst, ctr}), 32'h3);
      {xs, xt} <= 2'b00;
      sg <= 3'($urandom);
      settle(3);
      rdx(8'h34, 32'h1);
      for (int f = 0; f < 3; f++) begin
         bus(1, 8'h00, 32'(f * 2 + 1));
         rdx(8'h34, 32'h1 << f);
      end
      bus(1, 8'h00, 32'h4);
      rdx(8'h34, 32'h1);
      $display("test common done");
      r = 18'($urandom);
      {iof, sf, di, pr, lt_req, rss, rsb, phs, phb} <= r;
      settle(8);
      rdx(8'h24, 32'(r));
      check("ev_off_acc", 32'(off_acc), 32'h0);
      $display("test status done");
      tally_and_finish();
   end
endmodule
